// [src/dtc_pkg.sv]
`default_nettype none
package dtc_pkg;

  // ------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------
  localparam int DTC_ADDR_W = 12;
  localparam int DTC_DATA_W = 32;
  localparam int DTC_REG_W  = 16;
  localparam int DTC_IDX_W  = 10;

  // ------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [DTC_IDX_W-1:0] DTC_AUX_UPPER_IDX  = 10'h04A;
  localparam logic [DTC_IDX_W-1:0] DTC_SW_SHORT_IDX   = 10'h04B;
  localparam logic [DTC_IDX_W-1:0] DTC_SW_LOW_IDX     = 10'h04C;
  localparam logic [DTC_IDX_W-1:0] DTC_ALERT_STAT_IDX = 10'h060;
  localparam logic [DTC_IDX_W-1:0] DTC_ALERT_MASK_IDX = 10'h061;

  // ------------------------------------------------------------
  // Reset values and always-zero low bits
  // ------------------------------------------------------------
  localparam logic [DTC_REG_W-1:0] DTC_AUX_UPPER_RST = 16'hFFF0;
  localparam logic [DTC_REG_W-1:0] DTC_SW_SHORT_RST  = 16'h0000;
  localparam logic [DTC_REG_W-1:0] DTC_SW_LOW_RST    = 16'h0000;
  localparam int DTC_AUX_ZERO_BITS = 4;
  localparam int DTC_SW_ZERO_BITS  = 2;

  // ------------------------------------------------------------
  // Alert event bits in status and mask
  // ------------------------------------------------------------
  localparam int DTC_EV_W     = 3;
  localparam int DTC_EV_AUX   = 0;
  localparam int DTC_EV_SHORT = 1;
  localparam int DTC_EV_LOW   = 2;
  localparam logic [DTC_EV_W-1:0] DTC_EV_RST = 3'h0;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    DTC_MODE_NONE,
    DTC_MODE_SHORT,
    DTC_MODE_CONDUCT,
    DTC_MODE_SENSE
  } dtc_mode_t;

  typedef struct packed {
    logic                 valid;
    logic                 is_aux;
    dtc_mode_t            mode;
    logic [DTC_REG_W-1:0] value;
  } dtc_result_t;

endpackage : dtc_pkg
`default_nettype wire

// [src/dtc_limit_reg.sv]
`timescale 1ns/1ps
`default_nettype none
module dtc_limit_reg #(
  parameter int                     ZERO_BITS = 2,
  parameter logic [15:0]            RST_VAL   = 16'h0000
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 wr_en,
  input  wire logic [15:0]          wr_data,
  output logic      [15:0]          value
);
  import dtc_pkg::*;

  logic [15-ZERO_BITS:0] limit_reg;
  logic [15-ZERO_BITS:0] limit_next;

  // Low bits are never stored, so they cannot read back non-zero
  always_comb
  begin
    limit_next = limit_reg;
    if (wr_en)
    begin
      limit_next = wr_data[15:ZERO_BITS];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      limit_reg <= RST_VAL[15:ZERO_BITS];
    end
    else
    begin
      limit_reg <= limit_next;
    end
  end

  assign value = {limit_reg, {ZERO_BITS{1'b0}}};

endmodule // dtc_limit_reg
`default_nettype wire

// [src/dtc_compare.sv]
`timescale 1ns/1ps
`default_nettype none
module dtc_compare (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire dtc_pkg::dtc_result_t              result,
  input  wire logic [dtc_pkg::DTC_REG_W-1:0]     aux_limit,
  input  wire logic [dtc_pkg::DTC_REG_W-1:0]     short_limit,
  input  wire logic [dtc_pkg::DTC_REG_W-1:0]     low_limit,
  output logic      [dtc_pkg::DTC_EV_W-1:0]      hits
);
  import dtc_pkg::*;

  logic [DTC_EV_W-1:0] hits_reg;
  logic [DTC_EV_W-1:0] hits_next;

  // Equal counts as normal: only strictly beyond the limit alerts
  always_comb
  begin
    hits_next = '0;
    if (result.valid && result.is_aux)
    begin
      hits_next[DTC_EV_AUX] = result.value[15:4] > aux_limit[15:4];
    end
    if (result.valid && !result.is_aux)
    begin
      unique case (result.mode)
        DTC_MODE_SHORT:
          hits_next[DTC_EV_SHORT] = result.value[15:2] < short_limit[15:2];
        DTC_MODE_CONDUCT, DTC_MODE_SENSE:
          hits_next[DTC_EV_LOW] = result.value[15:2] < low_limit[15:2];
        DTC_MODE_NONE:
          hits_next = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hits_reg <= DTC_EV_RST;
    end
    else
    begin
      hits_reg <= hits_next;
    end
  end

  assign hits = hits_reg;

endmodule // dtc_compare
`default_nettype wire

// [src/dtc_top.sv]
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Aux upper limit 12 bits, resets FFF0h
// - Short mode result below limit alerts
// - Short limit low two bits read zero
// - Low limit resets zero, alerts below
// - Low limit low two bits read zero
module dtc_top (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [dtc_pkg::DTC_ADDR_W-1:0]    paddr,
  input  wire logic [dtc_pkg::DTC_DATA_W-1:0]    pwdata,
  input  wire logic [3:0]                        pstrb,
  output logic      [dtc_pkg::DTC_DATA_W-1:0]    prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire dtc_pkg::dtc_result_t              result,
  output logic                                   irq
);
  import dtc_pkg::*;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic dtc_hit(input logic [DTC_ADDR_W-1:0] addr,
                                   input logic [DTC_IDX_W-1:0]  idx);
    dtc_hit = (addr == {idx, 2'b00});
  endfunction

  logic                 setup;
  logic                 access;
  logic                 wr_ok;
  logic                 low_lanes;
  logic                 sel_aux;
  logic                 sel_short;
  logic                 sel_low;
  logic                 sel_stat;
  logic                 sel_mask;
  logic                 mapped;
  logic [DTC_REG_W-1:0] aux_limit;
  logic [DTC_REG_W-1:0] short_limit;
  logic [DTC_REG_W-1:0] low_limit;
  logic [DTC_EV_W-1:0]  hits;
  logic                 pready_reg;
  logic                 pslverr_reg;

  assign setup     = psel && !penable;
  assign access    = psel && penable && pready_reg;
  // Limits are 16 bits wide: a write needs both low byte lanes
  assign low_lanes = pstrb[1] && pstrb[0];
  assign wr_ok     = access && pwrite && low_lanes && !pslverr_reg;
  assign sel_aux   = dtc_hit(paddr, DTC_AUX_UPPER_IDX);
  assign sel_short = dtc_hit(paddr, DTC_SW_SHORT_IDX);
  assign sel_low   = dtc_hit(paddr, DTC_SW_LOW_IDX);
  assign sel_stat  = dtc_hit(paddr, DTC_ALERT_STAT_IDX);
  assign sel_mask  = dtc_hit(paddr, DTC_ALERT_MASK_IDX);
  assign mapped    = sel_aux || sel_short || sel_low || sel_stat || sel_mask;

  // ------------------------------------------------------------
  // Limit registers and comparison
  // ------------------------------------------------------------
  dtc_limit_reg #(
    .ZERO_BITS (DTC_AUX_ZERO_BITS),
    .RST_VAL   (DTC_AUX_UPPER_RST)
  ) u_aux_upper (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_ok && sel_aux),
    .wr_data (pwdata[DTC_REG_W-1:0]),
    .value   (aux_limit)
  );

  dtc_limit_reg #(
    .ZERO_BITS (DTC_SW_ZERO_BITS),
    .RST_VAL   (DTC_SW_SHORT_RST)
  ) u_sw_short (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_ok && sel_short),
    .wr_data (pwdata[DTC_REG_W-1:0]),
    .value   (short_limit)
  );

  dtc_limit_reg #(
    .ZERO_BITS (DTC_SW_ZERO_BITS),
    .RST_VAL   (DTC_SW_LOW_RST)
  ) u_sw_low (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_ok && sel_low),
    .wr_data (pwdata[DTC_REG_W-1:0]),
    .value   (low_limit)
  );

  // Limits are used as they stand; a diagnostic run before they are
  // programmed compares against reset values
  dtc_compare u_compare (
    .pclk        (pclk),
    .presetn     (presetn),
    .result      (result),
    .aux_limit   (aux_limit),
    .short_limit (short_limit),
    .low_limit   (low_limit),
    .hits        (hits)
  );

  // ------------------------------------------------------------
  // Alert status, mask and interrupt
  // ------------------------------------------------------------
  logic [DTC_EV_W-1:0] stat_reg;
  logic [DTC_EV_W-1:0] stat_next;
  logic [DTC_EV_W-1:0] mask_reg;
  logic [DTC_EV_W-1:0] mask_next;
  logic                irq_reg;
  logic                irq_next;

  always_comb
  begin
    stat_next = stat_reg;
    mask_next = mask_reg;
    if (wr_ok && sel_stat)
    begin
      stat_next = stat_reg & ~pwdata[DTC_EV_W-1:0];
    end
    if (wr_ok && sel_mask)
    begin
      mask_next = pwdata[DTC_EV_W-1:0];
    end
    // A hit in the clearing cycle is kept: set wins
    stat_next = stat_next | hits;
    irq_next  = |(stat_next & mask_next);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_reg <= DTC_EV_RST;
      mask_reg <= DTC_EV_RST;
      irq_reg  <= 1'b0;
    end
    else
    begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg  <= irq_next;
    end
  end

  // ------------------------------------------------------------
  // APB answer, prepared in the setup cycle
  // ------------------------------------------------------------
  logic [DTC_DATA_W-1:0] prdata_reg;
  logic [DTC_DATA_W-1:0] prdata_next;
  logic                  pready_next;
  logic                  pslverr_next;

  always_comb
  begin
    prdata_next  = '0;
    pready_next  = setup;
    pslverr_next = setup && !mapped;
    if (setup && !pwrite)
    begin
      unique case (1'b1)
        sel_aux:   prdata_next[DTC_REG_W-1:0] = aux_limit;
        sel_short: prdata_next[DTC_REG_W-1:0] = short_limit;
        sel_low:   prdata_next[DTC_REG_W-1:0] = low_limit;
        sel_stat:  prdata_next[DTC_EV_W-1:0]  = stat_reg;
        sel_mask:  prdata_next[DTC_EV_W-1:0]  = mask_reg;
        default:   prdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq     = irq_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence aux_over_s;
    result.valid && result.is_aux && (result.value[15:4] > aux_limit[15:4]);
  endsequence

  sequence short_under_s;
    result.valid && !result.is_aux && (result.mode == DTC_MODE_SHORT)
      && (result.value[15:2] < short_limit[15:2]);
  endsequence

  sequence low_under_s;
    result.valid && !result.is_aux
      && (result.mode inside {DTC_MODE_CONDUCT, DTC_MODE_SENSE})
      && (result.value[15:2] < low_limit[15:2]);
  endsequence

  aux_reset_val_a: assert property (
    @(posedge pclk) $rose(presetn) |-> (aux_limit == DTC_AUX_UPPER_RST))
    else $error("aux upper limit not at reset value");

  aux_read_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready_reg && !pwrite && sel_aux) |-> (prdata_reg[3:0] == 4'h0))
    else $error("aux upper limit low nibble read non-zero");

  aux_alert_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    aux_over_s |=> hits[DTC_EV_AUX] ##1 stat_reg[DTC_EV_AUX])
    else $error("aux alert not raised");

  short_alert_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    short_under_s |=> hits[DTC_EV_SHORT] ##1 stat_reg[DTC_EV_SHORT])
    else $error("short alert not raised");

  short_normal_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (result.valid && result.mode == DTC_MODE_SHORT && !result.is_aux
      && result.value[15:2] >= short_limit[15:2]) |=> !hits[DTC_EV_SHORT])
    else $error("short alert raised on normal result");

  short_read_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready_reg && !pwrite && sel_short) |-> (prdata_reg[1:0] == 2'h0))
    else $error("short limit low bits read non-zero");

  low_alert_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    low_under_s |=> hits[DTC_EV_LOW] ##1 stat_reg[DTC_EV_LOW])
    else $error("low alert not raised");

  low_reset_val_a: assert property (
    @(posedge pclk) $rose(presetn) |-> (low_limit == DTC_SW_LOW_RST))
    else $error("low limit not at reset value");

  low_read_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pready_reg && !pwrite && sel_low) |-> (prdata_reg[1:0] == 2'h0))
    else $error("low limit low bits read non-zero");

  irq_level_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (|(stat_reg & mask_reg)) |-> ##[0:1] irq_reg)
    else $error("interrupt missing for unmasked alert");

  aux_normal_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (result.valid && result.is_aux && (result.value[15:4] <= aux_limit[15:4]))
      |=> !hits[DTC_EV_AUX])
    else $error("aux alert raised on normal result");

  low_normal_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (result.valid && !result.is_aux
      && (result.mode inside {DTC_MODE_CONDUCT, DTC_MODE_SENSE})
      && (result.value[15:2] >= low_limit[15:2])) |=> !hits[DTC_EV_LOW])
    else $error("low alert raised on normal result");

  // A write missing a low byte lane would leave a limit half old, half new: refuse it
  strobe_ignore_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && pwrite && !low_lanes)
      |=> ($stable(aux_limit) && $stable(short_limit) && $stable(low_limit)))
    else $error("limit changed by partial strobe write");

  pready_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready_reg ##1 !pready_reg)
    else $error("ready not a one-cycle pulse after setup");

  unmapped_err_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup |=> (pslverr_reg == !$past(mapped)))
    else $error("error flag wrong for address");

  prdata_idle_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pready_reg |-> (prdata_reg == '0))
    else $error("read data not zero outside answer");

  stat_sticky_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_ok && sel_stat) |=> ((stat_reg & $past(stat_reg)) == $past(stat_reg)))
    else $error("alert status bit lost without clear");

  irq_match_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_reg == (|(stat_reg & mask_reg)))
    else $error("interrupt does not follow masked status");

endmodule // dtc_top
`default_nettype wire

// [tb/dtc_adc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dtc_adc_model
  import dtc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        fire,
  input  wire dtc_result_t req,
  output dtc_result_t      result
);
  // ------------------------------------------------------------
  // Result source
  // ------------------------------------------------------------
  // Fires only when the bench says so, after the limits are set
  // Idle clears valid, so an idle bus never looks valid; stale is_aux and value are inverted, mode is held
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result <= '0;
    else if (fire)
      result <= '{1'b1, req.is_aux, req.mode, req.value};
    else
      result <= '{1'b0, ~result.is_aux, result.mode, ~result.value};
  end
endmodule // dtc_adc_model
`default_nettype wire

// [tb/dtc_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module dtc_top_bench;
  import dtc_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        fire = 1'b0;
  dtc_result_t req = '0;
  dtc_result_t result;
  logic [31:0] rd;
  logic        er;
  logic [2:0]  msk = 3'h0;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cycles = 0;

  always #5 pclk = ~pclk;

  dtc_top dtc_top_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .result  (result),
    .irq     (irq)
  );

  dtc_adc_model dtc_adc_model_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .fire    (fire),
    .req     (req),
    .result  (result)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One edge first, so back-to-back calls never drive psel twice at one time
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, er}, 32'h0);
  endtask

  // Clear status, fire one result, then check status and interrupt line
  task automatic diag(input logic aux, input dtc_mode_t m, input logic [15:0] v,
                      input logic [2:0] exp);
    apb(1'b1, 12'h180, 32'h7);
    @(posedge pclk);
    fire <= 1'b1;
    req  <= '{1'b1, aux, m, v};
    @(posedge pclk);
    fire <= 1'b0;
    repeat (5) @(posedge pclk);
    chk({31'h0, irq}, {31'h0, |(exp & msk)});
    rchk(12'h180, {29'h0, exp});
  endtask

  // ------------------------------------------------------------
  // Timeout
  // ------------------------------------------------------------
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rchk(12'h128, 32'h0000FFF0);
    rchk(12'h130, 32'h00000000);
    rchk(12'h12C, 32'h00000000);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h128, 32'h0000FFFF);
    rchk(12'h128, 32'h0000FFF0);
    apb(1'b1, 12'h12C, 32'h0000FFFF);
    rchk(12'h12C, 32'h0000FFFC);
    apb(1'b1, 12'h130, 32'h0000FFFF);
    rchk(12'h130, 32'h0000FFFC);
    apb(1'b0, 12'h200, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 12'h200, 32'h0000FFFF);
    chk({31'h0, er}, 32'h1);
    // Low byte lane missing: the write must not land
    pstrb <= 4'hE;
    apb(1'b1, 12'h128, 32'h00001230);
    pstrb <= 4'hF;
    rchk(12'h128, 32'h0000FFF0);
    // Limits go in before any diagnostic result is produced
    apb(1'b1, 12'h128, 32'h00008000);
    apb(1'b1, 12'h12C, 32'h00004000);
    apb(1'b1, 12'h130, 32'h00002000);
    msk = 3'h7;
    apb(1'b1, 12'h184, 32'h7);
    rchk(12'h184, 32'h7);
    diag(1'b1, DTC_MODE_NONE, 16'h8010, 3'h1);
    diag(1'b1, DTC_MODE_NONE, 16'h800F, 3'h0);
    diag(1'b0, DTC_MODE_SHORT, 16'h3FFC, 3'h2);
    diag(1'b0, DTC_MODE_SHORT, 16'h4003, 3'h0);
    diag(1'b0, DTC_MODE_CONDUCT, 16'h1FFC, 3'h4);
    diag(1'b0, DTC_MODE_SENSE, 16'h1FFC, 3'h4);
    diag(1'b0, DTC_MODE_SENSE, 16'h2000, 3'h0);
    diag(1'b0, DTC_MODE_NONE, 16'h0000, 3'h0);
    msk = 3'h0;
    apb(1'b1, 12'h184, 32'h0);
    diag(1'b1, DTC_MODE_NONE, 16'hFFF0, 3'h1);
    apb(1'b1, 12'h184, 32'h1);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h180, 32'h1);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rchk(12'h180, 32'h0);
    // Reset in mid-run must bring back the aux limit, low limit and mask values lost by the writes above
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(12'h128, 32'h0000FFF0);
    rchk(12'h130, 32'h00000000);
    rchk(12'h184, 32'h0);
    chk({31'h0, irq}, 32'h0);
    tally_and_finish();
  end
endmodule // dtc_top_bench
`default_nettype wire
